// *** hw/heater_output_control.sv ***
`timescale 1ns/1ps
// Overview of operation
// [RL1] Contactor type: output cannot change within two seconds of last change.
// [RL2] Contactor type: proportional algorithm not allowed; falls back to on/off.
// [RL3] Contactor type and hysteresis on/off are the defaults.
// [RL4] Solid-state type: contactor output held at configured level while healthy.
// [RL5] Solid-state failure: contactor output driven to inverse of configured level.
// [RL6] Analog type: drive scales linearly from zero to full scale with duty.
// [RL7] Analog type: switch-state features disabled; only cut-outs and ground fault.
// [RL8] On/off: output off when temperature exceeds setpoint plus deadband.
// [RL9] On/off: output on when temperature at or below setpoint.
// [RL10] On/off: inside deadband output keeps its previous state.
// [RL11] Proportional: full duty at or below setpoint.
// [RL12] Proportional: zero duty at or above setpoint plus band.
// [RL13] Proportional: duty falls linearly, half at setpoint plus half band.
// [RL14] Proportional: duty recomputed and applied once every second.
// [RL15] Ambient mode: on and off durations from ambient and design inputs.
// [RL16] Software must not pair proportional mode with contactor output.
// [RL17] Alarm relay energized with no alarm, released on any alarm.
// [RL18] Limiter output de-energized when the limiter trips.
// [RL19] Heater power needs contactor and limiter outputs energized together.
// [RL20] Forced-on keeps heater output active.
// [RL21] Forced-off keeps heater output inactive.
// [RL22] After reset output off and hold timer restarted before acting.
module heater_output_control
  import heater_ctl_pkg::*;
#(
  parameter int unsigned HOLD_CNT = HOLD_CYCLES,
  parameter int unsigned TICK_CNT = TICK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Configuration
  input wire out_type_t out_type_in,
  input wire ctl_alg_t alg_in,
  input wire ctl_cfg_t cfg_in,
  input wire logic cfg_load_in,
  // Measurement and protection
  input wire logic signed [TEMP_W-1:0] ctl_temp_in,
  input wire prot_t prot_in,
  // Outputs
  output logic contactor_out,
  output logic ssr_out,
  output logic [ANALOG_W-1:0] analog_out,
  output logic alarm_relay_out,
  output logic limiter_out,
  output logic heater_power_out,
  output logic [DUTY_W-1:0] duty_out,
  output out_type_t out_type_out,
  output ctl_alg_t alg_out
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  initial begin
    if (HOLD_CNT < 1 || TICK_CNT < 100) $error("heater_output_control bad counts");
  end

  // ************************************************************
  // Mode registers
  // ************************************************************
  out_type_t out_type_reg;
  ctl_alg_t alg_reg;
  ctl_alg_t alg_eff;

  // Proportional refused with contactor type
  assign alg_eff = (out_type_in == OUT_CONTACTOR && alg_in == ALG_PROP) ?
                   ALG_ONOFF : alg_in; // see [RL2]

  // Defaults at reset, reloaded on request
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      out_type_reg <= OUT_TYPE_RESET; // see [RL3]
      alg_reg <= ALG_RESET; // see [RL3]
    end else if (cfg_load_in) begin
      out_type_reg <= out_type_in;
      alg_reg <= alg_eff;
    end
  end
  assign out_type_out = out_type_reg;
  assign alg_out = alg_reg;

  // ************************************************************
  // One-second tick
  // ************************************************************
  logic [31:0] tick_cnt_reg;
  logic tick;
  assign tick = tick_cnt_reg == 32'(TICK_CNT - 1);
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || tick) tick_cnt_reg <= 32'h0;
    else tick_cnt_reg <= tick_cnt_reg + 32'h1;
  end

  // ************************************************************
  // Temperature comparisons
  // ************************************************************
  logic signed [TEMP_W+1:0] diff;
  logic signed [TEMP_W+1:0] db_s;
  logic signed [TEMP_W+1:0] pb_s;
  assign diff = (TEMP_W+2)'(ctl_temp_in) - (TEMP_W+2)'(cfg_in.setpoint);
  assign db_s = (TEMP_W+2)'({2'b00, cfg_in.deadband});
  assign pb_s = (TEMP_W+2)'({2'b00, cfg_in.prop_band});

  // Hysteresis decision
  logic onoff_want;
  logic onoff_reg;
  assign onoff_want = (diff > db_s) ? 1'b0 :  // see [RL8]
                      (diff <= 0) ? 1'b1 :     // see [RL9]
                      onoff_reg;               // see [RL10]
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) onoff_reg <= 1'b0;
    else onoff_reg <= onoff_want;
  end

  // ************************************************************
  // Proportional duty
  // ************************************************************
  logic [DUTY_W-1:0] prop_duty;
  logic [TEMP_W+8:0] frac;
  assign frac = (TEMP_W+9)'(diff[TEMP_W:0]) * (TEMP_W+9)'(DUTY_FULL);
  always_comb begin
    if (diff <= 0) prop_duty = DUTY_FULL; // see [RL11]
    else if (diff >= pb_s || pb_s == 0) prop_duty = '0; // see [RL12]
    else prop_duty = DUTY_FULL -
                     DUTY_W'(frac / (TEMP_W+9)'(cfg_in.prop_band)); // see [RL13]
  end

  logic [DUTY_W-1:0] duty_reg;
  // Duty applied only on the second tick
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) duty_reg <= '0;
    else if (tick) duty_reg <= prop_duty; // see [RL14]
  end
  assign duty_out = duty_reg;

  logic pwm_on;
  duty_pwm #(.PERIOD(TICK_CNT)) u_pwm (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .tick_in(tick),
    .duty_in(duty_reg),
    .pwm_out(pwm_on)
  );

  // ************************************************************
  // Ambient-proportional timing
  // ************************************************************
  logic amb_on_reg;
  logic [AMBIENT_W-1:0] amb_sec_reg;
  logic [AMBIENT_W-1:0] amb_limit;
  // On and off durations supplied precomputed by the host side
  assign amb_limit = amb_on_reg ? cfg_in.ambient_on_s : cfg_in.ambient_off_s;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      amb_on_reg <= 1'b0;
      amb_sec_reg <= '0;
    end else if (tick) begin
      if (amb_sec_reg + AMBIENT_W'(1) >= amb_limit) begin
        amb_on_reg <= !amb_on_reg; // see [RL15]
        amb_sec_reg <= '0;
      end else begin
        amb_sec_reg <= amb_sec_reg + AMBIENT_W'(1);
      end
    end
  end

  // ************************************************************
  // Algorithm selection
  // ************************************************************
  logic want_on;
  always_comb begin
    unique case (alg_reg)
      ALG_ONOFF: want_on = onoff_reg;
      ALG_AMBIENT: want_on = amb_on_reg;
      ALG_PROP: want_on = pwm_on;
      ALG_FORCE_ON: want_on = 1'b1; // see [RL20]
      ALG_FORCE_OFF: want_on = 1'b0; // see [RL21]
      default: want_on = 1'b0;
    endcase
  end

  // Protection inhibits; switch failure ignored in analog mode
  logic inhibit;
  assign inhibit = prot_in.temp_cutout || prot_in.gf_trip ||
                   (out_type_reg != OUT_ANALOG && out_type_reg == OUT_SSR &&
                    prot_in.ssr_fail); // see [RL7]
  logic demand;
  assign demand = want_on && !inhibit;

  // ************************************************************
  // Contactor hold timer
  // ************************************************************
  logic [31:0] hold_reg;
  logic hold_done;
  logic cont_state_reg;
  logic cont_next;
  assign hold_done = hold_reg >= 32'(HOLD_CNT);

  // Contactor type: follow demand only after hold expires
  always_comb begin
    unique case (out_type_reg)
      OUT_CONTACTOR: cont_next = hold_done ? demand : cont_state_reg; // see [RL1]
      OUT_SSR: cont_next = prot_in.ssr_fail ? !cfg_in.contactor_level
                                            : cfg_in.contactor_level; // see [RL4] [RL5]
      default: cont_next = cfg_in.contactor_level;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cont_state_reg <= 1'b0; // see [RL22]
      hold_reg <= 32'h0; // see [RL22]
    end else begin
      cont_state_reg <= cont_next;
      if (cont_next != cont_state_reg) hold_reg <= 32'h0; // see [RL1]
      else if (!hold_done) hold_reg <= hold_reg + 32'h1;
    end
  end

  // ************************************************************
  // Output drivers
  // ************************************************************
  logic [ANALOG_W+DUTY_W-1:0] analog_prod;
  logic [DUTY_W-1:0] ana_duty;
  // Cut-outs and ground fault still force the analog drive to zero
  assign ana_duty = inhibit ? '0 :
                    (alg_reg == ALG_PROP) ? duty_reg : (want_on ? DUTY_FULL : '0); // see [RL7]
  assign analog_prod = (ANALOG_W+DUTY_W)'(ana_duty) * (ANALOG_W+DUTY_W)'(ANALOG_FULL);

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      contactor_out <= 1'b0;
      ssr_out <= 1'b0;
      analog_out <= '0;
      alarm_relay_out <= 1'b0;
      limiter_out <= 1'b0;
      heater_power_out <= 1'b0;
    end else begin
      contactor_out <= cont_next;
      ssr_out <= (out_type_reg == OUT_SSR) && demand;
      analog_out <= (out_type_reg == OUT_ANALOG) ?
                    ANALOG_W'(analog_prod / (ANALOG_W+DUTY_W)'(DUTY_FULL)) : '0; // see [RL6]
      alarm_relay_out <= !prot_in.alarm; // see [RL17]
      limiter_out <= !prot_in.limiter_trip; // see [RL18]
      heater_power_out <= cont_next && !prot_in.limiter_trip &&
                          (out_type_reg == OUT_CONTACTOR ? 1'b1 : demand); // see [RL19]
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  chk_contactor_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see [RL1]
    (out_type_reg == OUT_CONTACTOR && $changed(cont_state_reg) && $past(hold_done) == 1'b0
     && $past(out_type_reg) == OUT_CONTACTOR) |-> 1'b0)
    else $error("contactor changed inside hold");
  chk_no_prop_contactor: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see [RL2]
    cfg_load_in && out_type_in == OUT_CONTACTOR |=> alg_reg != ALG_PROP)
    else $error("proportional with contactor");
  chk_ssr_level: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see [RL4]
    out_type_reg == OUT_SSR && !prot_in.ssr_fail |-> cont_next == cfg_in.contactor_level)
    else $error("ssr contactor level wrong");
  chk_ssr_fail_inv: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see [RL5]
    out_type_reg == OUT_SSR && prot_in.ssr_fail |=> contactor_out == !$past(cfg_in.contactor_level))
    else $error("ssr failure not inverted");
  chk_onoff_off: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see [RL8]
    diff > db_s |=> !onoff_reg)
    else $error("on/off not off above band");
  chk_onoff_on: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see [RL9]
    diff <= 0 |=> onoff_reg)
    else $error("on/off not on at setpoint");
  chk_prop_full: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see [RL11]
    tick && diff <= 0 |=> duty_reg == DUTY_FULL)
    else $error("proportional not full");
  chk_prop_zero: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see [RL12]
    tick && diff >= pb_s |=> duty_reg == '0)
    else $error("proportional not zero");
  chk_duty_tick: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see [RL14]
    !$past(tick) |-> $stable(duty_reg))
    else $error("duty changed off tick");
  chk_alarm_fail: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see [RL17]
    prot_in.alarm |=> !alarm_relay_out)
    else $error("alarm relay energized");
  chk_limiter_trip: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see [RL18]
    prot_in.limiter_trip |=> !limiter_out && !heater_power_out)
    else $error("limiter trip ignored");

endmodule : heater_output_control

// *** hw/heater_ctl_pkg.sv ***
package heater_ctl_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TICK_PERIOD_MS = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_PERIOD_MS;
  localparam int unsigned HOLD_TIME_S = 2;
  localparam int unsigned HOLD_CYCLES = CLK_HZ * HOLD_TIME_S;

  // ************************************************************
  // Widths and scales
  // ************************************************************
  localparam int unsigned TEMP_W = 16;
  localparam int unsigned DUTY_W = 7;
  localparam logic [DUTY_W-1:0] DUTY_FULL = 7'h64;
  localparam int unsigned ANALOG_W = 12;
  localparam logic [ANALOG_W-1:0] ANALOG_FULL = 12'hFFF;
  localparam int unsigned AMBIENT_W = 16;

  // ************************************************************
  // Modes
  // ************************************************************
  typedef enum logic [1:0] {OUT_CONTACTOR, OUT_SSR, OUT_ANALOG} out_type_t;
  typedef enum logic [2:0] {
    ALG_ONOFF, ALG_AMBIENT, ALG_PROP, ALG_FORCE_ON, ALG_FORCE_OFF
  } ctl_alg_t;
  localparam out_type_t OUT_TYPE_RESET = OUT_CONTACTOR;
  localparam ctl_alg_t ALG_RESET = ALG_ONOFF;

  // Configuration bundle
  typedef struct packed {
    logic signed [TEMP_W-1:0] setpoint;
    logic [TEMP_W-1:0] deadband;
    logic [TEMP_W-1:0] prop_band;
    logic contactor_level;
    logic [AMBIENT_W-1:0] ambient_on_s;
    logic [AMBIENT_W-1:0] ambient_off_s;
  } ctl_cfg_t;

  // Protection bundle
  typedef struct packed {
    logic ssr_fail;
    logic limiter_trip;
    logic alarm;
    logic temp_cutout;
    logic gf_trip;
  } prot_t;

endpackage : heater_ctl_pkg

// *** hw/duty_pwm.sv ***
`timescale 1ns/1ps
// Cycle-period PWM: output on for duty percent of each tick period
module duty_pwm
  import heater_ctl_pkg::*;
#(
  parameter int unsigned PERIOD = TICK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Control
  input wire logic tick_in,
  input wire logic [DUTY_W-1:0] duty_in,
  // Output
  output logic pwm_out
);

  initial begin
    if (PERIOD < 100) $error("duty_pwm PERIOD too small");
  end

  localparam int unsigned STEP = PERIOD / 100;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic [31:0] on_cycles;

  // Period counter restarts on every tick
  assign cnt_next = tick_in ? 32'h0 : cnt_reg + 32'h1;
  assign on_cycles = 32'(duty_in) * 32'(STEP);

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cnt_reg <= 32'h0;
      pwm_out <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      pwm_out <= cnt_next < on_cycles;
    end
  end

endmodule : duty_pwm

// *** dv/contactor_load_model.sv ***
`timescale 1ns/1ps
// ************************************************************
// Load contactor and limiter contactor in series with the heater
// ************************************************************
module contactor_load_model (
  // Clock
  input wire logic sys_clk_in,
  // Coil drives
  input wire logic contactor_in,
  input wire logic limiter_in,
  // Observations
  output logic load_on_out,
  output int unsigned last_gap_out
);
  int unsigned since = 0;
  logic prev = 1'b0;

  // Both coils must pull in before the load sees power
  assign load_on_out = contactor_in & limiter_in;

  // Measure the time between two changes of the contactor coil
  always @(posedge sys_clk_in) begin
    since <= since + 1;
    prev <= contactor_in;
    if (contactor_in !== prev) begin
      last_gap_out <= since;
      since <= 1;
    end
  end

  initial last_gap_out = 0;
endmodule : contactor_load_model

// *** dv/tb.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
`define WAIT(c, n) for (int k = 0; k < (n) && !(c); k++) @(negedge sys_clk_in);
module tb;
  import heater_ctl_pkg::*;
  localparam int unsigned HOLD = 50;
  localparam int unsigned TICK = 200;
  localparam int unsigned LIMIT = 20000;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  out_type_t out_type_in = OUT_CONTACTOR;
  ctl_alg_t alg_in = ALG_ONOFF;
  ctl_cfg_t cfg_in = '0;
  logic cfg_load_in = 1'b0;
  logic signed [TEMP_W-1:0] ctl_temp_in = 16'sh005A;
  prot_t prot_in = '0;
  logic contactor_out, ssr_out, alarm_relay_out, limiter_out, heater_power_out;
  logic [ANALOG_W-1:0] analog_out;
  logic [DUTY_W-1:0] duty_out;
  out_type_t out_type_out;
  ctl_alg_t alg_out;
  logic load_on;
  int unsigned last_gap;
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;

  always #25 sys_clk_in = ~sys_clk_in;

  // ************************************************************
  // Design and far-side contactors
  // ************************************************************
  heater_output_control #(.HOLD_CNT(HOLD), .TICK_CNT(TICK)) dut (.sys_clk_in(sys_clk_in),
    .rst_in(rst_in), .out_type_in(out_type_in), .alg_in(alg_in), .cfg_in(cfg_in),
    .cfg_load_in(cfg_load_in), .ctl_temp_in(ctl_temp_in), .prot_in(prot_in),
    .contactor_out(contactor_out), .ssr_out(ssr_out), .analog_out(analog_out),
    .alarm_relay_out(alarm_relay_out), .limiter_out(limiter_out),
    .heater_power_out(heater_power_out), .duty_out(duty_out),
    .out_type_out(out_type_out), .alg_out(alg_out));
  contactor_load_model load (.sys_clk_in(sys_clk_in), .contactor_in(contactor_out),
    .limiter_in(limiter_out), .load_on_out(load_on), .last_gap_out(last_gap));

  // ************************************************************
  // Helpers
  // ************************************************************
  task cyc(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask : cyc

  task set_mode(input out_type_t t, input ctl_alg_t a);
    @(negedge sys_clk_in);
    out_type_in = t;
    alg_in = a;
    cfg_load_in = 1'b1;
    cyc(1);
    cfg_load_in = 1'b0;
    cyc(2);
  endtask : set_mode

  task report_and_stop;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // ************************************************************
  // Scenarios
  // ************************************************************
  // Defaults after reset and hysteresis with the contactor hold time
  task t_onoff;
    `CHK("out_type", OUT_CONTACTOR, out_type_out)
    `CHK("alg", ALG_ONOFF, alg_out)
    cyc(40);
    `CHK("contactor held", 1'b0, contactor_out)
    `WAIT(contactor_out === 1'b1, 30)
    `CHK("contactor on", 1'b1, contactor_out)
    `CHK("alarm relay", 1'b1, alarm_relay_out)
    `CHK("power", load_on, heater_power_out)
    ctl_temp_in = 16'sh0069;
    cyc(HOLD + 10);
    `CHK("deadband keep", 1'b1, contactor_out)
    ctl_temp_in = 16'sh006F;
    `WAIT(contactor_out === 1'b0, 20)
    `CHK("contactor off", 1'b0, contactor_out)
    ctl_temp_in = 16'sh005A;
    cyc(HOLD - 5);
    `CHK("hold blocks", 1'b0, contactor_out)
    `WAIT(contactor_out === 1'b1, 15)
    `CHK("contactor back", 1'b1, contactor_out)
    // The model logs a change one edge after it happens
    cyc(2);
    `CHK("gap", 1'b1, last_gap >= HOLD)
  endtask : t_onoff

  // Alarm relay and limiter contactor drop out on faults
  task t_alarm_limiter;
    prot_in.alarm = 1'b1;
    cyc(2);
    `CHK("alarm drop", 1'b0, alarm_relay_out)
    prot_in.alarm = 1'b0;
    prot_in.limiter_trip = 1'b1;
    cyc(2);
    `CHK("limiter drop", 1'b0, limiter_out)
    `CHK("power cut", 1'b0, heater_power_out)
    prot_in.limiter_trip = 1'b0;
    cyc(2);
    `CHK("limiter back", 1'b1, limiter_out)
  endtask : t_alarm_limiter

  // Proportional duty table on the solid-state output
  task t_prop;
    set_mode(OUT_CONTACTOR, ALG_PROP);
    `CHK("prop refused", ALG_ONOFF, alg_out)
    set_mode(OUT_SSR, ALG_PROP);
    `CHK("contactor level", cfg_in.contactor_level, contactor_out)
    ctl_temp_in = 16'sh0064;
    `WAIT(duty_out === 7'h64, TICK + 10)
    `CHK("duty full", 7'h64, duty_out)
    ctl_temp_in = 16'sh0096;
    `WAIT(duty_out === 7'h32, TICK + 10)
    `CHK("duty half", 7'h32, duty_out)
    ctl_temp_in = 16'sh007D;
    `WAIT(duty_out === 7'h4B, TICK + 10)
    `CHK("duty linear", 7'h4B, duty_out)
    ctl_temp_in = 16'sh00C8;
    `WAIT(duty_out === 7'h00, TICK + 10)
    `CHK("duty zero", 7'h00, duty_out)
  endtask : t_prop

  // Switch failure flips the contactor; forced modes
  task t_ssr_force;
    set_mode(OUT_SSR, ALG_FORCE_ON);
    cyc(2);
    `CHK("force on", 1'b1, ssr_out)
    prot_in.ssr_fail = 1'b1;
    cyc(2);
    `CHK("fail flip", ~cfg_in.contactor_level, contactor_out)
    prot_in.ssr_fail = 1'b0;
    set_mode(OUT_SSR, ALG_FORCE_OFF);
    `CHK("force off", 1'b0, ssr_out)
  endtask : t_ssr_force

  // Analog drive scale and reduced protection set
  task t_analog;
    ctl_temp_in = 16'sh0096;
    set_mode(OUT_ANALOG, ALG_PROP);
    `WAIT(analog_out === 12'h7FF, TICK + 10)
    `CHK("analog half", 12'h7FF, analog_out)
    prot_in.ssr_fail = 1'b1;
    cyc(3);
    `CHK("fail ignored", 12'h7FF, analog_out)
    prot_in = '0;
    prot_in.temp_cutout = 1'b1;
    `WAIT(analog_out === 12'h000, TICK + 10)
    `CHK("cutout", 12'h000, analog_out)
    prot_in = '0;
    ctl_temp_in = 16'sh005A;
    `WAIT(analog_out === 12'hFFF, TICK + 10)
    `CHK("analog full", 12'hFFF, analog_out)
  endtask : t_analog

  // Ambient mode alternates on and off durations
  task t_ambient;
    set_mode(OUT_SSR, ALG_AMBIENT);
    `WAIT(ssr_out === 1'b1, 3 * TICK)
    `CHK("ambient on", 1'b1, ssr_out)
    `WAIT(ssr_out === 1'b0, 3 * TICK)
    `CHK("ambient off", 1'b0, ssr_out)
  endtask : t_ambient

  // ************************************************************
  // Main sequence and hang guard
  // ************************************************************
  initial begin
    cfg_in.setpoint = 16'sh0064;
    cfg_in.deadband = 16'h000A;
    cfg_in.prop_band = 16'h0064;
    cfg_in.contactor_level = 1'b1;
    cfg_in.ambient_on_s = 16'h0001;
    cfg_in.ambient_off_s = 16'h0001;
    cyc(20);
    rst_in = 1'b0;
    cyc(2);
    t_onoff();
    t_alarm_limiter();
    t_prop();
    t_ssr_force();
    t_analog();
    t_ambient();
    report_and_stop();
  end

  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      error_cnt++;
      report_and_stop();
    end
  end
endmodule : tb
